// ===== verilog/dbal_pkg.sv
// Shared constants and types for the drop bus alarm latch and one-second status block.
package dbal_pkg;

    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int REG_W = 8;
    localparam int NTRIB = 3;
    localparam int LATCH_W = 2 * NTRIB;
    localparam int SUM_W = NTRIB + 2;
    localparam int H4_PHASE_W = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'h60;
    localparam logic [7:0] IDX_LATCH = 8'h63;
    localparam logic [7:0] IDX_SUMMARY = 8'h64;
    localparam logic [7:0] IDX_INT_STATUS = 8'h68;
    localparam logic [7:0] IDX_INT_ENABLE = 8'h69;
    localparam logic [7:0] IDX_INT_CLEAR = 8'h6a;

    function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'h0, idx, 2'h0};
    endfunction

    // Field positions.
    localparam int OOM_LSB = 3;
    localparam int LOM_LSB = 0;
    localparam int AIS_LSB = 2;
    localparam int PAR_BIT = 1;
    localparam int LOC_BIT = 0;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MFSEL_BIT = 2;
    localparam int CTRL_W = 3;

    // Transition select encodings.
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    localparam logic [CTRL_W-1:0] CTRL_RESET = {1'b0, EDGE_BOTH};
    localparam logic [LATCH_W-1:0] LATCH_RESET = 6'h00;
    localparam logic [SUM_W-1:0] SUM_RESET = 5'h00;

    // Timing.
    localparam int CLK_HZ = 50_000_000;
    localparam int LOM_TIME_US = 1000;
    localparam int LOM_CYCLES_DEF = (CLK_HZ / 1_000_000) * LOM_TIME_US;
    localparam int SEC_TIMEOUT_MS = 2000;
    localparam int SEC_TIMEOUT_DEF = (CLK_HZ / 1000) * SEC_TIMEOUT_MS;
    localparam int H4_RUN_LEN = 4;

    typedef enum logic [2:0] {
        MF_ALIGNED = 3'h1,
        MF_OUT = 3'h2,
        MF_LOST = 3'h4
    } dbal_mf_state_t;

endpackage

// ===== verilog/dbal_h4_align.sv
// H4 multiframe alignment monitor for one tributary: out-of and loss-of multiframe.
`timescale 1ns/1ps
module dbal_h4_align #(
    parameter int LOM_CYCLES = dbal_pkg::LOM_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic h4_strobe,
    input wire logic [dbal_pkg::H4_PHASE_W-1:0] h4_phase,
    output logic oom,
    output logic lom
);
    import dbal_pkg::*;

    localparam int TW = $clog2(LOM_CYCLES + 1);
    localparam logic [TW-1:0] TMAX = TW'(LOM_CYCLES);
    localparam logic [H4_PHASE_W-1:0] LAST_PHASE = H4_PHASE_W'(H4_RUN_LEN - 1);

    dbal_mf_state_t state_q;
    logic [H4_PHASE_W-1:0] expect_q;
    logic [H4_PHASE_W-1:0] run_q;
    logic [TW-1:0] timer_q;
    logic recovered;

    // R10 four clean frames
    assign recovered = h4_strobe && (h4_phase == run_q) && (run_q == LAST_PHASE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MF_ALIGNED;
            expect_q <= '0;
            run_q <= '0;
        // R12 detection gated
        end else if (!enable) begin
            state_q <= MF_ALIGNED;
            expect_q <= '0;
            run_q <= '0;
        end else begin
            case (state_q)
                MF_ALIGNED: begin
                    // R10 any error declares
                    if (h4_strobe) begin
                        expect_q <= h4_phase + 1'b1;
                        if (h4_phase != expect_q) begin
                            state_q <= MF_OUT;
                            run_q <= (h4_phase == '0) ? 2'h1 : 2'h0;
                        end
                    end
                end
                MF_OUT, MF_LOST: begin
                    if (recovered) begin
                        state_q <= MF_ALIGNED;
                        expect_q <= '0;
                        run_q <= '0;
                    end else begin
                        if (h4_strobe) begin
                            if (h4_phase == run_q) begin
                                run_q <= run_q + 1'b1;
                            end else begin
                                run_q <= (h4_phase == '0) ? 2'h1 : 2'h0;
                            end
                        end
                        // R11 loss after timeout
                        if (state_q == MF_OUT && timer_q == TMAX) begin
                            state_q <= MF_LOST;
                        end
                    end
                end
                default: begin
                    state_q <= MF_ALIGNED;
                end
            endcase
        end
    end

    // Time spent in MF_OUT; held at zero in MF_LOST; restarts every time alignment is lost anew.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_q <= '0;
        end else if (state_q != MF_OUT) begin
            timer_q <= '0;
        end else if (timer_q != TMAX) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    assign oom = (state_q != MF_ALIGNED);
    assign lom = (state_q == MF_LOST);

endmodule

// ===== verilog/dbal_top.sv
// Drop bus A-side multiframe alarm latch and one-second alarm summary with APB access.
//
// Overview of operation
// R1 - OOM latches for tributaries three, two and one sit in bits 5, 4 and 3 of the latch register.
// R2 - LOM latches for tributaries three, two and one sit in bits 2, 1 and 0 of the latch register.
// R3 - A latch bit sets on a rising, falling or either transition of its alarm, as selected.
// R4 - Reading the latch register clears the bits it returned once the read completes.
// R5 - Upstream AIS summaries for tributaries three, two and one sit in bits 4, 3 and 2.
// R6 - Parity alarm summary sits in bit 1 and loss-of-clock summary in bit 0.
// R7 - Each interval end sets a summary bit if its alarm changed or is active, else clears it.
// R8 - Summary bits stay clear while no one-second pulse arrives.
// R9 - Summary bits never reach the interrupt output.
// R10 - OOM is declared on any H4 phase error and left after four frames of 00, 01, 10, 11.
// R11 - LOM is declared after 1 ms of OOM and cleared when alignment returns.
// R12 - H4 detection runs only while the multiframe source select bit is 0.
// R13 - Unused upper bits read as zero and writes to both alarm registers are ignored.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module dbal_top #(
    parameter int LOM_CYCLES = dbal_pkg::LOM_CYCLES_DEF,
    parameter int SEC_TIMEOUT_CYCLES = dbal_pkg::SEC_TIMEOUT_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dbal_pkg::APB_AW-1:0] paddr,
    input wire logic [dbal_pkg::APB_DW-1:0] pwdata,
    output logic [dbal_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [dbal_pkg::NTRIB-1:0] h4_strobe,
    input wire logic [dbal_pkg::NTRIB*dbal_pkg::H4_PHASE_W-1:0] h4_phase,
    input wire logic [dbal_pkg::NTRIB-1:0] upstream_ais,
    input wire logic drop_parity_alarm,
    input wire logic drop_clock_loss_alarm,
    input wire logic one_sec_pin,
    output logic irq
);
    import dbal_pkg::*;

    localparam int WW = $clog2(SEC_TIMEOUT_CYCLES + 1);
    localparam logic [WW-1:0] WMAX = WW'(SEC_TIMEOUT_CYCLES);

    // Mode select decides which alarm edges count as events.
    function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] mode);
        logic rise;
        logic fall;
        rise = cur && !prev;
        fall = prev && !cur;
        case (mode)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            default: edge_hit = rise || fall;
        endcase
    endfunction

    function automatic logic [REG_W-1:0] widen(input logic [LATCH_W-1:0] v);
        widen = {{(REG_W-LATCH_W){1'b0}}, v};
    endfunction

    // Write strobe for one register: true only at the completing edge of a write to it.
    function automatic logic wr_hit(input logic done, input logic wr,
        input logic [APB_AW-1:0] addr, input logic [7:0] idx);
        wr_hit = done && wr && (addr == reg_addr(idx));
    endfunction

    // Control register.
    logic [CTRL_W-1:0] ctrl_q;
    logic [1:0] edge_mode;
    logic mf_select;

    // Alarm state.
    logic [NTRIB-1:0] oom;
    logic [NTRIB-1:0] lom;
    logic [LATCH_W-1:0] alarm_now;
    logic [LATCH_W-1:0] alarm_prev_q;
    logic [LATCH_W-1:0] latch_set;
    logic [LATCH_W-1:0] latch_q;
    logic [LATCH_W-1:0] latch_clr;

    // One-second summary state.
    logic [SUM_W-1:0] sum_now;
    logic [SUM_W-1:0] sum_prev_q;
    logic [SUM_W-1:0] sum_chg_q;
    logic [SUM_W-1:0] summary_q;
    logic sec_meta_q;
    logic sec_sync_q;
    logic sec_last_q;
    logic sec_tick;
    logic [WW-1:0] watchdog_q;
    logic sec_alive;

    // Interrupt state.
    logic [LATCH_W-1:0] int_status_q;
    logic [LATCH_W-1:0] int_enable_q;
    logic [LATCH_W-1:0] int_clr;

    // Bus state.
    logic setup;
    logic access_done;
    logic rd_latch_q;
    logic [REG_W-1:0] rd_mux;
    logic rd_hit;

    assign edge_mode = ctrl_q[CTRL_MODE_LSB +: 2];
    assign mf_select = ctrl_q[CTRL_MFSEL_BIT];

    // H4 alignment monitors, one per tributary position.
    for (genvar t = 0; t < NTRIB; t++) begin : g_trib
        dbal_h4_align #(
            .LOM_CYCLES(LOM_CYCLES)
        ) u_align (
            .pclk(pclk),
            .presetn(presetn),
            // R12 detection enable
            .enable(!mf_select),
            .h4_strobe(h4_strobe[t]),
            .h4_phase(h4_phase[t*H4_PHASE_W +: H4_PHASE_W]),
            .oom(oom[t]),
            .lom(lom[t])
        );
    end

    // R1 OOM bit placement
    assign alarm_now[OOM_LSB +: NTRIB] = oom;
    // R2 LOM bit placement
    assign alarm_now[LOM_LSB +: NTRIB] = lom;

    // R5 AIS bit placement
    assign sum_now[AIS_LSB +: NTRIB] = upstream_ais;
    // R6 parity and clock loss
    assign sum_now[PAR_BIT] = drop_parity_alarm;
    assign sum_now[LOC_BIT] = drop_clock_loss_alarm;

    // R3 selected transition detect
    always_comb begin
        for (int i = 0; i < LATCH_W; i++) begin
            latch_set[i] = edge_hit(alarm_prev_q[i], alarm_now[i], edge_mode);
        end
    end

    // The copy resets to the idle level of the alarms, so no false edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_prev_q <= LATCH_RESET;
        end else begin
            alarm_prev_q <= alarm_now;
        end
    end

    // APB phases: the answer is prepared in the setup cycle, so access needs no wait state.
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready;

    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            reg_addr(IDX_CTRL): rd_mux = {{(REG_W-CTRL_W){1'b0}}, ctrl_q};
            reg_addr(IDX_LATCH): rd_mux = widen(latch_q);
            reg_addr(IDX_SUMMARY): rd_mux = {{(REG_W-SUM_W){1'b0}}, summary_q};
            reg_addr(IDX_INT_STATUS): rd_mux = widen(int_status_q);
            reg_addr(IDX_INT_ENABLE): rd_mux = widen(int_enable_q);
            reg_addr(IDX_INT_CLEAR): rd_mux = '0;
            default: begin
                rd_mux = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            rd_latch_q <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !rd_hit;
            // R13 upper bits zero
            prdata <= {{(APB_DW-REG_W){1'b0}}, rd_mux};
            rd_latch_q <= !pwrite && (paddr == reg_addr(IDX_LATCH));
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            rd_latch_q <= 1'b0;
        end
    end

    // R4 clear after read
    // Only the bits that were actually returned are cleared, so an event that lands
    // between setup and completion survives for the next read.
    assign latch_clr = (access_done && rd_latch_q) ? prdata[LATCH_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= LATCH_RESET;
        end else begin
            // R3 set wins over clear
            latch_q <= (latch_q & ~latch_clr) | latch_set;
        end
    end

    // Control register; R13 keeps the two alarm registers free of any write path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_hit(access_done, pwrite, paddr, IDX_CTRL)) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_enable_q <= '0;
        end else if (wr_hit(access_done, pwrite, paddr, IDX_INT_ENABLE)) begin
            int_enable_q <= pwdata[LATCH_W-1:0];
        end
    end

    assign int_clr = wr_hit(access_done, pwrite, paddr, IDX_INT_CLEAR) ?
                     pwdata[LATCH_W-1:0] : '0;

    // R9 latch events only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_q <= '0;
        end else begin
            int_status_q <= (int_status_q & ~int_clr) | latch_set;
        end
    end

    // The interrupt follows the next status value, so it rises with the status bit and
    // drops at the very edge that clears it; the one-second summaries are no part of it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_status_q & ~int_clr) | latch_set) & int_enable_q);
        end
    end

    // One-second pulse arrives from a pin and is synchronised before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_meta_q <= 1'b0;
            sec_sync_q <= 1'b0;
            sec_last_q <= 1'b0;
        end else begin
            sec_meta_q <= one_sec_pin;
            sec_sync_q <= sec_meta_q;
            sec_last_q <= sec_sync_q;
        end
    end

    assign sec_tick = sec_sync_q && !sec_last_q;

    // R8 pulse watchdog
    // A missing pulse is judged by a timeout; until it expires the old summary stands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_q <= WMAX;
        end else if (sec_tick) begin
            watchdog_q <= '0;
        end else if (watchdog_q != WMAX) begin
            watchdog_q <= watchdog_q + 1'b1;
        end
    end

    assign sec_alive = (watchdog_q != WMAX);

    // Previous-cycle copy of the summarised alarms, used to spot changes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_prev_q <= SUM_RESET;
        end else begin
            sum_prev_q <= sum_now;
        end
    end

    // R7 change tracking
    // A change seen in the tick cycle belongs to the interval that just ended.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_chg_q <= SUM_RESET;
        end else if (sec_tick) begin
            sum_chg_q <= SUM_RESET;
        end else begin
            sum_chg_q <= sum_chg_q | (sum_now ^ sum_prev_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_q <= SUM_RESET;
        end else if (sec_tick) begin
            // R7 interval end update
            summary_q <= sum_chg_q | (sum_now ^ sum_prev_q) | sum_now;
        end else if (!sec_alive) begin
            // R8 inactive without pulse
            summary_q <= SUM_RESET;
        end
    end

endmodule

// ===== tb/dbal_h4_source.sv
// Frame source model: H4 strobes with a running multiframe phase for three tributaries.
`timescale 1ns/1ps
module dbal_h4_source #(
    parameter int FRAME = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] err_mask,
    output logic [2:0] h4_strobe,
    output logic [5:0] h4_phase
);
    logic [3:0] tick_q;
    logic [1:0] ph_q;
    logic fr;
    assign fr = tick_q == FRAME - 1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
            ph_q <= '0;
        end else begin
            tick_q <= fr ? '0 : tick_q + 1'b1;
            if (fr) begin
                ph_q <= ph_q + 1'b1;
            end
        end
    end
    // phase sequence
    // A fixed phase of 2 never starts a recovery run, so a masked tributary stays lost.
    // Between strobes the phase is inverted, since it is only valid with its strobe.
    always_comb begin
        h4_strobe = {3{fr}};
        for (int i = 0; i < 3; i++) begin
            h4_phase[2*i +: 2] = err_mask[i] ? 2'h2 : (fr ? ph_q : ~ph_q);
        end
    end
endmodule

// ===== tb/dbal_top_assertions.sv
// Concurrent checks on the register bus side of the alarm latch block.
`timescale 1ns/1ps
module dbal_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [dbal_pkg::APB_AW-1:0] paddr,
    input wire logic [dbal_pkg::APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import dbal_pkg::*;
    logic [9:0] idx;
    logic mapped;
    assign idx = paddr[11:2];
    assign mapped = paddr[1:0] == 2'h0 && (idx == IDX_CTRL || idx == IDX_LATCH ||
        idx == IDX_SUMMARY || idx == IDX_INT_STATUS || idx == IDX_INT_ENABLE ||
        idx == IDX_INT_CLEAR);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_gets_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    error_map_a: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address map");
    error_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    latch_spare_a: assert property (pready && idx == IDX_LATCH |-> prdata[7:6] == 2'h0)
        else $error("latch spare bits set");
    summary_spare_a: assert property (pready && idx == IDX_SUMMARY |-> prdata[7:5] == 3'h0)
        else $error("summary spare bits set");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
endmodule
bind dbal_top dbal_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== tb/dbal_top_tb_top.sv
// Self-checking bench for the drop bus alarm latch and one-second summary block.
`timescale 1ns/1ps
module dbal_top_tb_top;
    import dbal_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, one_sec_pin;
    logic drop_parity_alarm, drop_clock_loss_alarm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] h4_strobe, upstream_ais, err_mask;
    logic [5:0] h4_phase;
    int fail_count = 0;
    int comparisons = 0;
    // Short counts keep the run brief; every interval below but the 250-cycle no-pulse wait stays well inside 200 cycles.
    dbal_top #(.LOM_CYCLES(20), .SEC_TIMEOUT_CYCLES(200)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .h4_strobe(h4_strobe), .h4_phase(h4_phase), .upstream_ais(upstream_ais),
        .drop_parity_alarm(drop_parity_alarm), .drop_clock_loss_alarm(drop_clock_loss_alarm),
        .one_sec_pin(one_sec_pin), .irq(irq));
    dbal_h4_source u_src (.pclk(pclk), .presetn(presetn), .err_mask(err_mask),
        .h4_strobe(h4_strobe), .h4_phase(h4_phase));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            fail_count++;
            $display("BAD pready expected 1 seen %b", pready);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(nm, exp, r);
    endtask
    task automatic pulse();
        one_sec_pin <= 1'b1;
        cyc(4);
        one_sec_pin <= 1'b0;
        cyc(8);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(IDX_LATCH, 32'h0, "latch reset");
        rd(IDX_SUMMARY, 32'h0, "summary before pulse");
        rd(IDX_CTRL, 32'h2, "ctrl reset");
        wr(IDX_LATCH, 32'hff);
        rd(IDX_LATCH, 32'h0, "latch after write");
        apb(1'b0, 8'h01, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask
    task automatic t_row(input logic [2:0] mask, input logic [2:0] ctrl, input logic [5:0] en,
        input logic [7:0] set_v, input logic [7:0] clr_v, input logic exp_irq);
        wr(IDX_CTRL, {29'h0, ctrl});
        wr(IDX_INT_ENABLE, {26'h0, en});
        wr(IDX_INT_CLEAR, 32'h3f);
        err_mask <= mask;
        cyc(60);
        rd(IDX_LATCH, {24'h0, set_v}, "latch on loss");
        chk("irq", {31'h0, exp_irq}, {31'h0, irq});
        rd(IDX_INT_STATUS, {24'h0, set_v}, "int status");
        rd(IDX_INT_ENABLE, {26'h0, en}, "int enable");
        rd(IDX_LATCH, 32'h0, "latch after read");
        err_mask <= 3'h0;
        cyc(100);
        rd(IDX_LATCH, {24'h0, clr_v}, "latch on recovery");
    endtask
    task automatic t_sec();
        wr(IDX_INT_CLEAR, 32'h3f);
        upstream_ais <= 3'h5;
        drop_parity_alarm <= 1'b1;
        pulse();
        rd(IDX_SUMMARY, 32'h16, "summary active");
        chk("irq with summary", 32'h0, {31'h0, irq});
        upstream_ais <= 3'h2;
        drop_parity_alarm <= 1'b0;
        pulse();
        rd(IDX_SUMMARY, 32'h1e, "summary changed");
        drop_clock_loss_alarm <= 1'b1;
        cyc(3);
        drop_clock_loss_alarm <= 1'b0;
        pulse();
        rd(IDX_SUMMARY, 32'h09, "summary glitch");
        wr(IDX_SUMMARY, 32'hff);
        rd(IDX_SUMMARY, 32'h09, "summary after write");
        pulse();
        rd(IDX_SUMMARY, 32'h08, "summary steady");
        cyc(250);
        rd(IDX_SUMMARY, 32'h0, "summary without pulse");
        chk("irq from summary", 32'h0, {31'h0, irq});
    endtask
    initial begin
        #400000;
        fail_count++;
        $display("BAD run expected finish seen timeout");
        close_out();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        upstream_ais = 3'h0;
        err_mask = 3'h0;
        drop_parity_alarm = 1'b0;
        drop_clock_loss_alarm = 1'b0;
        one_sec_pin = 1'b0;
        cyc(8);
        presetn <= 1'b1;
        t_reset();
        t_row(3'h7, 3'h2, 6'h3f, 8'h3f, 8'h3f, 1'b1);
        t_row(3'h1, 3'h0, 6'h00, 8'h09, 8'h00, 1'b0);
        t_row(3'h1, 3'h1, 6'h3f, 8'h00, 8'h09, 1'b0);
        t_row(3'h7, 3'h6, 6'h3f, 8'h00, 8'h00, 1'b0);
        t_sec();
        close_out();
    end
endmodule
